/* File: ccr_pkg.sv */
/*
 * ccr_pkg: codes, command encodings, event and report carriers for the
 * command completion code reporter.
 * assumes: nothing beyond a SystemVerilog compiler.
 */
package ccr_pkg;

  // interrupt codes
  localparam logic [7:0] CCR_IC_RESET     = 8'h01;
  localparam logic [7:0] CCR_IC_REG_PAR   = 8'h22;
  localparam logic [7:0] CCR_IC_MSG_PAR   = 8'h24;
  localparam logic [7:0] CCR_IC_TIMEOUT   = 8'h2C;
  localparam logic [7:0] CCR_IC_BUS_FREE  = 8'h31;
  localparam logic [7:0] CCR_IC_DONE      = 8'h60;
  localparam logic [7:0] CCR_IC_ABANDON   = 8'h64;
  localparam logic [7:0] CCR_IC_ILLEGAL   = 8'h65;
  localparam logic [7:0] CCR_IC_PAUSED    = 8'h67;
  localparam logic [7:0] CCR_IC_DIAG_GOOD = 8'h68;
  localparam logic [7:0] CCR_IC_DIAG_BAD  = 8'h69;
  localparam logic [7:0] CCR_IC_FREE_PRE  = 8'h70;

  // step codes
  localparam logic [7:0] CCR_ST_0 = 8'h00;
  localparam logic [7:0] CCR_ST_1 = 8'h01;

  // message-in lengths
  localparam logic [5:0] CCR_EXT_EARLY_BYTES = 6'h02;

  // housekeeping command encodings presented on the command port
  typedef enum logic [3:0] {
    CCR_CMD_XFER_RESET = 4'h0,
    CCR_CMD_SETUP_REG  = 4'h1,
    CCR_CMD_BUS_RESET  = 4'h2,
    CCR_CMD_INIT_DIAG  = 4'h3,
    CCR_CMD_TARG_DIAG  = 4'h4,
    CCR_CMD_SELFTEST_FINISH_CMD   = 4'h5,
    CCR_CMD_PAUSE      = 4'h6,
    CCR_CMD_SET_RST    = 4'h7,
    CCR_CMD_CLR_RST    = 4'h8
  } ccr_cmd_t;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] step;
  } ccr_report_t;

  // bus-side conditions on sys_clk: one-cycle pulses, except nexus and arb_or_data, which are levels
  typedef struct packed {
    logic reset_cond;
    logic bus_free;
    logic nexus;
    logic arb_or_data;
    logic diag_done;
    logic diag_pass;
  } ccr_bus_ev_t;

  // reselection message-in events
  typedef struct packed {
    logic       resel;
    logic       nexus_made;
    logic       byte_valid;
    logic       byte_parity_err;
    logic       last_byte;
    logic       extended;
    logic       timeout;
    logic       bus_free;
    logic       reset_cond;
  } ccr_resel_ev_t;

  // what the main block needs from the message-in tracker
  typedef struct packed {
    logic        valid;
    ccr_report_t rpt;
  } ccr_resel_out_t;

  function automatic ccr_report_t ccr_mk(input logic [7:0] c, input logic [7:0] s);
    ccr_report_t r;
    r.code = c;
    r.step = s;
    return r;
  endfunction

endpackage

/* File: ccr_resel_msgin.sv */
/*
 * ccr_resel_msgin: tracks automatic reselection response and the
 * message-in transfer that follows, and yields one completion report when it ends in an error.
 * assumes: event inputs are one-cycle pulses on sys_clk from bus logic.
 */
`timescale 1ns/10ps
`default_nettype none

module ccr_resel_msgin
  import ccr_pkg::*;
(
  input  wire logic           sys_clk,
  input  wire logic           srst,
  input  wire ccr_resel_ev_t  ev,
  input  wire logic           taken,
  output ccr_resel_out_t      out,
  output logic                abort_now
);

  typedef enum logic [1:0] {
    CCR_RS_IDLE  = 2'b00,
    CCR_RS_WAIT  = 2'b01,
    CCR_RS_MSGIN = 2'b10,
    CCR_RS_HOLD  = 2'b11
  } ccr_rs_state_t;

  typedef struct packed {
    ccr_rs_state_t  st;
    logic [5:0]     cnt;
    logic           par_seen;
    ccr_resel_out_t o;
  } ccr_rs_t;

  ccr_rs_t cur_ff;
  ccr_rs_t nxt_cur;

  always_comb begin
    logic       par_now;
    logic [5:0] cnt_inc;
    nxt_cur = cur_ff;
    abort_now = 1'b0;
    par_now = cur_ff.par_seen | (ev.byte_valid & ev.byte_parity_err);
    cnt_inc = cur_ff.cnt + 6'h01;
    case (cur_ff.st)
      CCR_RS_IDLE: begin
        if (ev.resel) begin
          nxt_cur.st = CCR_RS_WAIT;
          nxt_cur.cnt = '0;
          nxt_cur.par_seen = 1'b0;
        end
      end
      CCR_RS_WAIT: begin
        if (ev.reset_cond) begin
          nxt_cur.o.rpt = ccr_mk(CCR_IC_RESET, CCR_ST_0);
          nxt_cur.st = CCR_RS_HOLD;
        end else if (ev.nexus_made) begin
          nxt_cur.st = CCR_RS_MSGIN;
        end
      end
      CCR_RS_MSGIN: begin
        // terminating errors end the transfer in the detecting cycle
        if (ev.reset_cond) begin
          abort_now = 1'b1;
          nxt_cur.o.rpt = ccr_mk(CCR_IC_RESET, CCR_ST_1);
          nxt_cur.st = CCR_RS_HOLD;
        end else if (ev.timeout) begin
          abort_now = 1'b1;
          nxt_cur.o.rpt = ccr_mk(CCR_IC_TIMEOUT, CCR_ST_1);
          nxt_cur.st = CCR_RS_HOLD;
        end else if (ev.bus_free) begin
          abort_now = 1'b1;
          nxt_cur.o.rpt = ccr_mk(CCR_IC_BUS_FREE, CCR_ST_1);
          nxt_cur.st = CCR_RS_HOLD;
        end else if (ev.byte_valid) begin
          nxt_cur.cnt = cnt_inc;
          nxt_cur.par_seen = par_now;
          // parity held back until the whole message, or two bytes of extended
          if (par_now && (ev.last_byte ||
              (ev.extended && cnt_inc == CCR_EXT_EARLY_BYTES))) begin
            nxt_cur.o.rpt = ccr_mk(CCR_IC_MSG_PAR, CCR_ST_1);
            nxt_cur.st = CCR_RS_HOLD;
          end else if (ev.last_byte) begin
            nxt_cur.st = CCR_RS_IDLE; // clean message: reported elsewhere
          end
        end
      end
      CCR_RS_HOLD: begin
        nxt_cur.o.valid = 1'b1;
        if (taken) begin
          nxt_cur.o.valid = 1'b0;
          nxt_cur.st = CCR_RS_IDLE;
        end
      end
      default: nxt_cur.st = CCR_RS_IDLE;
    endcase
    if (cur_ff.st != CCR_RS_HOLD) begin
      nxt_cur.o.valid = (nxt_cur.st == CCR_RS_HOLD);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign out = cur_ff.o;

endmodule

`default_nettype wire

/* File: ccr_top.sv */
/*
 * ccr_top: command completion code reporter. takes housekeeping
 * commands from the host processor, watches bus conditions, and
 * presents interrupt and step codes with a held interrupt request.
 * assumes: all inputs are on sys_clk; command and condition inputs are
 * one-cycle pulses, nexus and arb_or_data levels; the host acknowledges each report with int_ack.
 */
// What this block does
// - command during execution reports 64H/00H after the first result
// - interrupt source before execution abandons command; report source, then 64H/00H
// - undefined command gives 65H/00H; host register parity error gives 22H/00H
// - reset/setup/bus-reset: 60H/01H, bus free before gives 70H/00H
// - reset condition before housekeeping or diagnosis start reports 01H/00H
// - diagnosis start with nexus established is refused with 65H/01H
// - diagnosis result reports 68H/01H pass, 69H/01H fail
// - diagnosis end: reset after execution 01H/01H, else 60H/01H
// - diagnosis end without start or after failure reports 65H/00H
// - pause reports 67H/01H only in arbitration or data phases
// - reselection reset before nexus reports 01H/00H
// - reset during message-in after reselection reports 01H/01H
// - message-in parity error 24H/01H, held until whole short message
// - extended message parity: early bytes after two, later after all
// - handshake timeout during message-in reports 2CH/01H
// - bus free during message-in reports 31H/01H
// - terminating errors end the operation; op_abort rises the cycle after detection
`timescale 1ns/10ps
`default_nettype none

module ccr_top
  import ccr_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          srst,
  input  wire logic          cmd_valid,
  input  wire logic [3:0]    cmd_code,
  input  wire logic          reg_parity_err,
  input  wire ccr_bus_ev_t   bus_ev,
  input  wire ccr_resel_ev_t resel_ev,
  input  wire logic          int_ack,
  output logic               int_req,
  output ccr_report_t        int_rpt,
  output logic               cmd_busy,
  output logic               diag_run,
  output logic               rst_line_drive,
  output logic               op_abort
);

  typedef enum logic [2:0] {
    CCR_IDLE  = 3'b000,
    CCR_EXEC  = 3'b001,
    CCR_DIAG  = 3'b010,
    CCR_DEND  = 3'b011,
    CCR_PAUSE = 3'b100
  } ccr_state_t;

  typedef struct packed {
    ccr_state_t  st;
    ccr_cmd_t    cmd;
    logic        diag_active;  // start issued; cleared at diagnosis end or reset, not on failure
    logic        diag_failed;
    logic        dbl_pend;     // second command seen while busy
    logic        rst_line;
    logic        have_rpt;     // primary report waiting
    ccr_report_t rpt;
    logic        have_tail;    // follow-up 64H waiting behind primary
    logic        req;
    ccr_report_t shown;
    logic        abort;
    logic        par_pend;     // host register parity error waiting
  } ccr_core_t;

  ccr_core_t      cur_ff;
  ccr_core_t      nxt_cur;
  ccr_resel_out_t resel_out;
  logic           resel_abort;
  logic           resel_taken;

  function automatic logic ccr_cmd_defined(input logic [3:0] c);
    return c <= CCR_CMD_CLR_RST;
  endfunction

  function automatic logic ccr_is_house(input ccr_cmd_t c);
    return c == CCR_CMD_XFER_RESET || c == CCR_CMD_SETUP_REG ||
           c == CCR_CMD_BUS_RESET;
  endfunction

  ccr_resel_msgin u_resel (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .ev        (resel_ev),
    .taken     (resel_taken),
    .out       (resel_out),
    .abort_now (resel_abort)
  );

  always_comb begin
    logic     busy;
    ccr_cmd_t ncmd;
    nxt_cur = cur_ff;
    nxt_cur.abort = resel_abort;
    resel_taken = 1'b0;
    busy = (cur_ff.st != CCR_IDLE) || cur_ff.have_rpt;
    ncmd = ccr_cmd_t'(cmd_code);

    // command intake; a register parity error waits in its own flag, so it
    // is never lost behind a command or a report still pending
    if (cmd_valid && busy) begin
      nxt_cur.dbl_pend = 1'b1;
    end else if (cmd_valid && !ccr_cmd_defined(cmd_code)) begin
      nxt_cur.rpt = ccr_mk(CCR_IC_ILLEGAL, CCR_ST_0);
      nxt_cur.have_rpt = 1'b1;
    end else if (cmd_valid) begin
      nxt_cur.cmd = ncmd;
      case (ncmd)
        CCR_CMD_INIT_DIAG, CCR_CMD_TARG_DIAG: begin
          if (bus_ev.nexus) begin
            nxt_cur.rpt = ccr_mk(CCR_IC_ILLEGAL, CCR_ST_1);
            nxt_cur.have_rpt = 1'b1;
          end else begin
            nxt_cur.st = CCR_DIAG;
            nxt_cur.diag_active = 1'b1;
            nxt_cur.diag_failed = 1'b0;
          end
        end
        CCR_CMD_SELFTEST_FINISH_CMD: begin
          if (!cur_ff.diag_active || cur_ff.diag_failed) begin
            nxt_cur.rpt = ccr_mk(CCR_IC_ILLEGAL, CCR_ST_0);
            nxt_cur.have_rpt = 1'b1;
            nxt_cur.diag_failed = 1'b0;
          end else begin
            nxt_cur.st = CCR_DEND;
          end
        end
        CCR_CMD_PAUSE: nxt_cur.st = CCR_PAUSE;
        CCR_CMD_SET_RST, CCR_CMD_CLR_RST: begin
          nxt_cur.rst_line = (ncmd == CCR_CMD_SET_RST);
          nxt_cur.rpt = ccr_mk(CCR_IC_DONE, CCR_ST_1);
          nxt_cur.have_rpt = 1'b1;
        end
        default: nxt_cur.st = CCR_EXEC;
      endcase
    end

    // execution
    case (cur_ff.st)
      CCR_EXEC: begin
        nxt_cur.st = CCR_IDLE;
        nxt_cur.have_rpt = 1'b1;
        if (bus_ev.reset_cond) begin
          nxt_cur.rpt = ccr_mk(CCR_IC_RESET, CCR_ST_0);
          nxt_cur.have_tail = 1'b1;
        end else if (bus_ev.bus_free) begin
          nxt_cur.rpt = ccr_mk(CCR_IC_FREE_PRE, CCR_ST_0);
          nxt_cur.have_tail = 1'b1;
        end else if (ccr_is_house(cur_ff.cmd)) begin
          nxt_cur.rpt = ccr_mk(CCR_IC_DONE, CCR_ST_1);
        end
      end
      CCR_DIAG: begin
        if (bus_ev.reset_cond) begin
          nxt_cur.rpt = ccr_mk(CCR_IC_RESET, CCR_ST_0);
          nxt_cur.have_rpt = 1'b1;
          nxt_cur.have_tail = 1'b1;
          nxt_cur.diag_active = 1'b0;
          nxt_cur.st = CCR_IDLE;
        end else if (bus_ev.diag_done) begin
          nxt_cur.rpt = bus_ev.diag_pass ? ccr_mk(CCR_IC_DIAG_GOOD, CCR_ST_1)
                                         : ccr_mk(CCR_IC_DIAG_BAD, CCR_ST_1);
          nxt_cur.diag_failed = !bus_ev.diag_pass;
          nxt_cur.have_rpt = 1'b1;
          nxt_cur.st = CCR_IDLE;
        end
      end
      CCR_DEND: begin
        // reset seen in the execution cycle, right after acceptance, is the selftest_finish_cmd reset case
        nxt_cur.rpt = bus_ev.reset_cond ? ccr_mk(CCR_IC_RESET, CCR_ST_1)
                                        : ccr_mk(CCR_IC_DONE, CCR_ST_1);
        nxt_cur.have_rpt = 1'b1;
        nxt_cur.diag_active = 1'b0;
        nxt_cur.st = CCR_IDLE;
      end
      CCR_PAUSE: begin
        nxt_cur.st = CCR_IDLE;
        if (bus_ev.arb_or_data) begin
          nxt_cur.rpt = ccr_mk(CCR_IC_PAUSED, CCR_ST_1);
          nxt_cur.have_rpt = 1'b1;
        end
      end
      default: ;
    endcase

    // report presentation: primary, parity, reselection, then the 64H follow-up
    if (cur_ff.req) begin
      if (int_ack) begin
        nxt_cur.req = 1'b0;
      end
    end else if (cur_ff.have_rpt) begin
      nxt_cur.req = 1'b1;
      nxt_cur.shown = cur_ff.rpt;
      nxt_cur.have_rpt = 1'b0;
    end else if (cur_ff.par_pend) begin
      nxt_cur.req = 1'b1;
      nxt_cur.shown = ccr_mk(CCR_IC_REG_PAR, CCR_ST_0);
      nxt_cur.par_pend = 1'b0;
    end else if (resel_out.valid) begin
      resel_taken = 1'b1;
      nxt_cur.req = 1'b1;
      nxt_cur.shown = resel_out.rpt;
    end else if ((cur_ff.have_tail || cur_ff.dbl_pend) && cur_ff.st == CCR_IDLE) begin
      nxt_cur.req = 1'b1;
      nxt_cur.shown = ccr_mk(CCR_IC_ABANDON, CCR_ST_0);
      nxt_cur.have_tail = 1'b0;
      nxt_cur.dbl_pend = 1'b0;
    end

    // set wins over the drain in the same cycle
    if (reg_parity_err) begin
      nxt_cur.par_pend = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign int_req        = cur_ff.req;
  assign int_rpt        = cur_ff.shown;
  assign cmd_busy       = (cur_ff.st != CCR_IDLE);
  assign diag_run       = cur_ff.diag_active;
  assign rst_line_drive = cur_ff.rst_line;
  assign op_abort       = cur_ff.abort;

endmodule

`default_nettype wire

/* File: ccr_top_sva.sv */
/* ccr_top_sva: port-level checks of the completion code reporter.
   assumes: bound to ccr_top; everything runs on sys_clk. */
`timescale 1ns/10ps
`default_nettype none
module ccr_top_sva
  import ccr_pkg::*;
(
  input wire logic          sys_clk,
  input wire logic          srst,
  input wire logic          cmd_valid,
  input wire logic [3:0]    cmd_code,
  input wire logic          reg_parity_err,
  input wire ccr_bus_ev_t   bus_ev,
  input wire ccr_resel_ev_t resel_ev,
  input wire logic          int_ack,
  input wire logic          int_req,
  input wire ccr_report_t   int_rpt,
  input wire logic          cmd_busy,
  input wire logic          diag_run,
  input wire logic          rst_line_drive,
  input wire logic          op_abort
);
  logic idle;
  logic term;
  logic msg_ff;
  logic nxt_msg;
  assign idle = !cmd_busy && !int_req;
  assign term = resel_ev.timeout || resel_ev.bus_free || resel_ev.reset_cond;
  // message-in runs from nexus to the last byte or a terminating event
  assign nxt_msg = resel_ev.nexus_made
                   || (msg_ff && !term && !(resel_ev.byte_valid && resel_ev.last_byte));
  always_ff @(posedge sys_clk) begin
    msg_ff <= srst ? 1'b0 : nxt_msg;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  hold_rpt_a: assert property (int_req && !int_ack |=> int_req && $stable(int_rpt))
    else $error("report moved before ack");
  ack_drop_a: assert property (int_req && int_ack |=> !int_req)
    else $error("request kept after ack");
  undef_cmd_a: assert property (cmd_valid && cmd_code > 4'h8 && idle |-> ##2
    int_req && int_rpt == 16'h6500) else $error("undefined command report wrong");
  rst_line_a: assert property (cmd_valid && idle
    && cmd_code inside {CCR_CMD_SET_RST, CCR_CMD_CLR_RST} |-> ##2 int_req && int_rpt == 16'h6001)
    else $error("reset line command report wrong");
  diag_refuse_a: assert property (cmd_valid && idle && bus_ev.nexus
    && cmd_code inside {CCR_CMD_INIT_DIAG, CCR_CMD_TARG_DIAG} |-> ##2 int_rpt == 16'h6501)
    else $error("selftest start with nexus not refused");
  diag_result_a: assert property (bus_ev.diag_done && diag_run |-> ##2 int_req
    && int_rpt.code == ($past(bus_ev.diag_pass, 2) ? 8'h68 : 8'h69) && int_rpt.step == 8'h01)
    else $error("selftest result report wrong");
  pause_quiet_a: assert property (cmd_valid && idle && cmd_code == CCR_CMD_PAUSE
    && !bus_ev.arb_or_data |=> (!int_req) [*4]) else $error("pause outside phase interrupted");
  abort_now_a: assert property (msg_ff && term |=> op_abort)
    else $error("terminating error did not abort");
  msg_tmo_a: assert property (msg_ff && resel_ev.timeout |-> ##2 int_req
    && int_rpt == 16'h2C01) else $error("handshake timeout report wrong");
  msg_free_a: assert property (msg_ff && resel_ev.bus_free && !resel_ev.reset_cond
    |-> ##2 int_req && int_rpt == 16'h3101) else $error("bus free report wrong");
  msg_par_a: assert property (msg_ff && resel_ev.byte_valid && resel_ev.last_byte
    && !resel_ev.extended && resel_ev.byte_parity_err |-> ##2 int_req && int_rpt == 16'h2401)
    else $error("short message parity report wrong");
endmodule
bind ccr_top ccr_top_sva chk_u (.sys_clk(sys_clk), .srst(srst), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .reg_parity_err(reg_parity_err), .bus_ev(bus_ev),
  .resel_ev(resel_ev), .int_ack(int_ack), .int_req(int_req), .int_rpt(int_rpt),
  .cmd_busy(cmd_busy), .diag_run(diag_run), .rst_line_drive(rst_line_drive),
  .op_abort(op_abort));
`default_nettype wire

/* File: ccr_bus_model.sv */
/* ccr_bus_model: bus-side partner making condition and message-in events.
   assumes: tasks are called at a falling edge of sys_clk. */
`timescale 1ns/10ps
`default_nettype none
module ccr_bus_model
  import ccr_pkg::*;
(
  input  wire logic       sys_clk,
  output var ccr_bus_ev_t bus_ev,
  output var ccr_resel_ev_t resel_ev
);
  initial begin
    bus_ev = '0;
    resel_ev = '0;
  end
  task automatic set_lvl(input logic nx, input logic ad);
    bus_ev.nexus = nx;
    bus_ev.arb_or_data = ad;
  endtask
  task automatic pulse(input ccr_bus_ev_t p);
    bus_ev = bus_ev | p;
    @(negedge sys_clk);
    bus_ev = bus_ev & ~p;
  endtask
  task automatic rpulse(input ccr_resel_ev_t p);
    resel_ev = resel_ev | p;
    @(negedge sys_clk);
    resel_ev = resel_ev & ~p;
  endtask
  // bytes first..last of an n-byte message, one idle cycle between
  task automatic bytes(input int first, input int last, input int n, input logic ext,
                       input int err_at);
    for (int i = first; i <= last; i++) begin
      resel_ev.byte_valid = 1'b1;
      resel_ev.byte_parity_err = (i == err_at);
      resel_ev.last_byte = (i == n);
      resel_ev.extended = ext;
      @(negedge sys_clk);
      resel_ev.byte_valid = 1'b0;
      // parity and last-byte qualifiers flip when not valid so nobody may rely on stale values
      resel_ev.byte_parity_err = ~resel_ev.byte_parity_err;
      resel_ev.last_byte = ~resel_ev.last_byte;
      @(negedge sys_clk);
    end
  endtask
endmodule
`default_nettype wire

/* File: tb_command_completion_code_reporter.sv */
/* tb_command_completion_code_reporter: directed bench for ccr_top.
   assumes: ccr_bus_model plays the bus side; bench drives on falling edges. */
`timescale 1ns/10ps
`default_nettype none
module tb_command_completion_code_reporter;
  import ccr_pkg::*;
  localparam ccr_bus_ev_t B0 = 6'h00, BRST = 6'h20, BFREE = 6'h10, BPASS = 6'h03, BFAIL = 6'h02;
  localparam ccr_resel_ev_t RSEL = 9'h100, RNEX = 9'h080, RRST = 9'h001;
  logic sys_clk = 0, srst = 1, cmd_valid = 0, reg_parity_err = 0, int_ack = 0;
  logic [3:0] cmd_code = 4'h0;
  ccr_bus_ev_t bus_ev;
  ccr_resel_ev_t resel_ev;
  ccr_report_t int_rpt;
  logic int_req, cmd_busy, diag_run, rst_line_drive, op_abort;
  int err_count = 0, num_checks = 0, cyc = 0;
  always #25 sys_clk = ~sys_clk;
  ccr_bus_model bus_m (.sys_clk(sys_clk), .bus_ev(bus_ev), .resel_ev(resel_ev));
  ccr_top dut_u (.sys_clk(sys_clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .reg_parity_err(reg_parity_err), .bus_ev(bus_ev), .resel_ev(resel_ev), .int_ack(int_ack),
    .int_req(int_req), .int_rpt(int_rpt), .cmd_busy(cmd_busy), .diag_run(diag_run),
    .rst_line_drive(rst_line_drive), .op_abort(op_abort));
  task automatic print_verdict;
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait for the request, compare, then acknowledge
  task automatic expect_rpt(input logic [15:0] exp);
    int n;
    n = 0;
    while (int_req !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    cmp({15'h0, int_req}, 16'h0001);
    cmp(int_rpt, exp);
    int_ack = 1;
    @(negedge sys_clk);
    int_ack = 0;
    cmp({15'h0, int_req}, 16'h0000);
  endtask
  // ev lands in the execution cycle right after acceptance
  task automatic issue(input logic [3:0] c, input ccr_bus_ev_t ev);
    cmd_valid = 1;
    cmd_code = c;
    @(negedge sys_clk);
    cmd_valid = 0;
    bus_m.pulse(ev);
  endtask
  task automatic t_house;
    for (int c = 0; c < 3; c++) begin
      issue(c[3:0], B0);
      expect_rpt(16'h6001);
      issue(c[3:0], BFREE);
      expect_rpt(16'h7000);
      expect_rpt(16'h6400);
      issue(c[3:0], BRST);
      expect_rpt(16'h0100);
      expect_rpt(16'h6400);
    end
    issue(4'h3, BRST);
    expect_rpt(16'h0100);
    expect_rpt(16'h6400);
    issue(4'h7, B0);
    expect_rpt(16'h6001);
    cmp({15'h0, rst_line_drive}, 16'h0001);
    issue(4'h8, B0);
    expect_rpt(16'h6001);
    cmp({15'h0, rst_line_drive}, 16'h0000);
  endtask
  task automatic t_undef;
    for (int c = 9; c < 16; c++) begin
      issue(c[3:0], B0);
      expect_rpt(16'h6500);
    end
    reg_parity_err = 1;
    @(negedge sys_clk);
    reg_parity_err = 0;
    expect_rpt(16'h2200);
  endtask
  task automatic t_diag;
    issue(4'h5, B0);
    expect_rpt(16'h6500);
    bus_m.set_lvl(1, 0);
    issue(4'h3, B0);
    expect_rpt(16'h6501);
    issue(4'h4, B0);
    expect_rpt(16'h6501);
    bus_m.set_lvl(0, 0);
    issue(4'h3, B0);
    cmp({15'h0, diag_run}, 16'h0001);
    cmp({15'h0, cmd_busy}, 16'h0001);
    bus_m.pulse(BPASS);
    expect_rpt(16'h6801);
    issue(4'h5, B0);
    expect_rpt(16'h6001);
    cmp({15'h0, diag_run}, 16'h0000);
    cmp({15'h0, cmd_busy}, 16'h0000);
    issue(4'h4, B0);
    bus_m.pulse(BFAIL);
    expect_rpt(16'h6901);
    issue(4'h5, B0);
    expect_rpt(16'h6500);
    issue(4'h3, B0);
    bus_m.pulse(BPASS);
    expect_rpt(16'h6801);
    issue(4'h5, BRST);
    expect_rpt(16'h0101);
  endtask
  task automatic t_cmds;
    cmd_valid = 1;
    cmd_code = 4'h0;
    @(negedge sys_clk);
    cmd_code = 4'h1;
    @(negedge sys_clk);
    cmd_valid = 0;
    expect_rpt(16'h6001);
    expect_rpt(16'h6400);
    bus_m.set_lvl(0, 1);
    issue(4'h6, B0);
    expect_rpt(16'h6701);
    bus_m.set_lvl(0, 0);
    issue(4'h6, B0);
    repeat (6) @(negedge sys_clk);
    cmp({15'h0, int_req}, 16'h0000);
  endtask
  task automatic t_resel;
    bus_m.rpulse(RSEL);
    bus_m.rpulse(RRST);
    expect_rpt(16'h0100);
    for (int k = 0; k < 3; k++) begin
      bus_m.rpulse(RSEL);
      bus_m.rpulse(RNEX);
      bus_m.rpulse(9'h001 << k);
      cmp({15'h0, op_abort}, 16'h0001);
      expect_rpt(k == 0 ? 16'h0101 : (k == 1 ? 16'h3101 : 16'h2C01));
    end
    bus_m.rpulse(RSEL);
    bus_m.rpulse(RNEX);
    bus_m.bytes(1, 1, 2, 0, 1);
    cmp({15'h0, int_req}, 16'h0000);
    bus_m.bytes(2, 2, 2, 0, 1);
    expect_rpt(16'h2401);
    bus_m.rpulse(RSEL);
    bus_m.rpulse(RNEX);
    bus_m.bytes(1, 1, 1, 0, 1);
    expect_rpt(16'h2401);
    bus_m.rpulse(RSEL);
    bus_m.rpulse(RNEX);
    bus_m.bytes(1, 4, 5, 1, 3);
    cmp({15'h0, int_req}, 16'h0000);
    bus_m.bytes(5, 5, 5, 1, 3);
    expect_rpt(16'h2401);
    bus_m.rpulse(RSEL);
    bus_m.rpulse(RNEX);
    bus_m.bytes(1, 2, 6, 1, 1);
    expect_rpt(16'h2401);
  endtask
  initial begin
    repeat (10) @(negedge sys_clk);
    srst = 0;
    cmp({10'h000, int_req, cmd_busy, diag_run, rst_line_drive, op_abort, |int_rpt},
        16'h0000);
    t_house();
    t_undef();
    t_diag();
    t_cmds();
    t_resel();
    print_verdict();
  end
endmodule
`default_nettype wire
